// file: hw/sscr_defs.svh
// Offsets, field positions, masks and widths of the sleep-state bank
`ifndef SSCR_DEFS_SVH
`define SSCR_DEFS_SVH
// Register addresses (the capability address is an arbitrary choice)
`define SSCR_ADDR_W 12
`define SSCR_ADDR_CTRL 12'h0E2
`define SSCR_ADDR_INFO 12'h0CE
// Capability register fields
`define SSCR_INFO_TDP_BIT 29
`define SSCR_INFO_RATIO_LSB 40
`define SSCR_INFO_RATIO_MSB 47
// Control register fields
`define SSCR_CTRL_LIM_LSB 0
`define SSCR_CTRL_LIM_MSB 2
`define SSCR_CTRL_IORED_BIT 10
`define SSCR_CTRL_LOCK_BIT 15
`define SSCR_CTRL_DEM3_BIT 25
`define SSCR_CTRL_DEM1_BIT 26
// Bits writable in the control register
`define SSCR_CTRL_WMASK 64'h0000_0000_0600_8407
// Bits covered by the lock
`define SSCR_CTRL_LMASK 64'h0000_0000_0000_FFFF
// Unit of the efficiency ratio in MHz
`define SSCR_RATIO_UNIT_MHZ 100
`endif

// file: hw/sscr_pkg.sv
// Types shared by the sleep-state configuration bank
package sscr_pkg;
  // Package sleep-state limit encodings
  typedef enum logic [2:0] {
    SSCR_LIM_C0C1 = 3'h0,
    SSCR_LIM_C2 = 3'h1,
    SSCR_LIM_C6N = 3'h2,
    SSCR_LIM_C6R = 3'h3,
    SSCR_LIM_C7 = 3'h4,
    SSCR_LIM_C7S = 3'h5,
    SSCR_LIM_RSVD = 3'h6,
    SSCR_LIM_NONE = 3'h7
  } sscr_limit_t;
  // Core sleep-state request levels
  typedef enum logic [2:0] {
    SSCR_CS_C1 = 3'h1,
    SSCR_CS_C3 = 3'h3,
    SSCR_CS_C6 = 3'h6,
    SSCR_CS_C7 = 3'h7
  } sscr_cstate_t;
endpackage

// file: hw/sscr_demote.sv
// Sleep-state request demotion and I/O read redirection
`timescale 1ns/1ps
`include "sscr_defs.svh"
module sscr_demote #(
  parameter int IO_W = 16
) (
  input wire logic dem3_en,
  input wire logic dem1_en,
  input wire logic io_red_en,
  input wire logic [IO_W-1:0] io_base,
  input wire logic [2:0] req_state,
  input wire logic uncore_dem3,
  input wire logic uncore_dem1,
  input wire logic io_rd,
  input wire logic [IO_W-1:0] io_addr,
  output logic [2:0] grant_state,
  output logic io_hit
);
  // Demotion: C1 demotion wins over C3 demotion
  always_comb begin
    grant_state = req_state;
    if (dem1_en && uncore_dem1 && (req_state == sscr_pkg::SSCR_CS_C3 ||
        req_state == sscr_pkg::SSCR_CS_C6 ||
        req_state == sscr_pkg::SSCR_CS_C7)) begin
      grant_state = sscr_pkg::SSCR_CS_C1; // [R9]
    end else if (dem3_en && uncore_dem3 &&
        (req_state == sscr_pkg::SSCR_CS_C6 ||
        req_state == sscr_pkg::SSCR_CS_C7)) begin
      grant_state = sscr_pkg::SSCR_CS_C3; // [R8]
    end
  end
  // Matching I/O read is absorbed, not forwarded
  assign io_hit = io_red_en && io_rd && (io_addr == io_base); // [R6] [R10]
endmodule

// file: hw/sscr_top.sv
// Sleep-state configuration register bank with capability fields
`timescale 1ns/1ps
`include "sscr_defs.svh"
// Overview of operation
// R1: Bit 29 reads turbo power-limit programmability
// R2: Bits 47:40 report minimum ratio, 100 MHz steps
// R3: Bits 2:0 hold package limit, factory default
// R4: Limit codes 0..5 and 7 decode to states
// R5: No limit code selects C3
// R6: Bit 10 redirects captured I/O reads
// R7: Bit 15 locks bits 15:0 until reset
// R8: Bit 25 demotes C6/C7 to C3
// R9: Bit 26 demotes C3/C6/C7 to C1
// R10: Captured reads absorbed, not forwarded
// R11: Lock is write-once, cleared only by reset
// R12: Reserved bits read zero, writes ignored
module sscr_top #(
  parameter logic TDP_PROG = 1'b1,
  parameter logic [7:0] MIN_RATIO = 8'h08,
  parameter logic [2:0] LIMIT_DEFAULT = 3'h7,
  parameter int IO_W = 16
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [`SSCR_ADDR_W-1:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rdata,
  input wire logic [IO_W-1:0] io_base,
  input wire logic [2:0] req_state,
  input wire logic uncore_dem3,
  input wire logic uncore_dem1,
  input wire logic io_rd,
  input wire logic [IO_W-1:0] io_addr,
  output logic [2:0] grant_state,
  output logic io_hit,
  output logic io_forward,
  output logic [2:0] pkg_limit_state,
  output logic pkg_limit_none,
  output logic cfg_locked
);
  // Control register storage
  logic [63:0] ctrl_ff;
  logic [63:0] nxt_ctrl;
  // Read data holding register
  logic [63:0] rdata_ff;
  logic [63:0] nxt_rdata;
  // Capability register image
  logic [63:0] info_val;
  // Write mask after lock
  logic [63:0] wmask;
  // Factory default captured after reset release
  logic dflt_done_ff;
  logic nxt_dflt_done;

  // Capability image, all other bits zero
  always_comb begin
    info_val = 64'h0;
    info_val[`SSCR_INFO_TDP_BIT] = TDP_PROG; // [R1] [R12]
    info_val[`SSCR_INFO_RATIO_MSB:`SSCR_INFO_RATIO_LSB] = MIN_RATIO; // [R2]
  end

  // Next control value
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_dflt_done = 1'b1;
    // Lock freezes bits 15:0, lock bit included
    if (ctrl_ff[`SSCR_CTRL_LOCK_BIT]) begin
      wmask = `SSCR_CTRL_WMASK & ~`SSCR_CTRL_LMASK; // [R7] [R11]
    end else begin
      wmask = `SSCR_CTRL_WMASK; // [R12]
    end
    if (!dflt_done_ff) begin
      // Factory limit loaded on first edge after reset
      nxt_ctrl[`SSCR_CTRL_LIM_MSB:`SSCR_CTRL_LIM_LSB] = LIMIT_DEFAULT; // [R3]
    end else if (reg_wr && reg_addr == `SSCR_ADDR_CTRL) begin
      nxt_ctrl = (ctrl_ff & ~wmask) | (reg_wdata & wmask); // [R12]
    end
  end

  // Control register flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= 64'h0;
      dflt_done_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      dflt_done_ff <= nxt_dflt_done;
    end
  end

  // Read decode; unmapped reads zero
  always_comb begin
    nxt_rdata = 64'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        `SSCR_ADDR_CTRL: nxt_rdata = ctrl_ff;
        `SSCR_ADDR_INFO: nxt_rdata = info_val;
        default: nxt_rdata = 64'h0;
      endcase
    end
  end

  // Read data flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 64'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;

  // Limit decode: code 6 treated as no limit; C3 never a target
  always_comb begin
    pkg_limit_state = 3'h0;
    pkg_limit_none = 1'b0;
    unique case (sscr_pkg::sscr_limit_t'(ctrl_ff[2:0]))
      sscr_pkg::SSCR_LIM_C0C1: pkg_limit_state = 3'h1; // [R4]
      sscr_pkg::SSCR_LIM_C2: pkg_limit_state = 3'h2; // [R4]
      sscr_pkg::SSCR_LIM_C6N: pkg_limit_state = 3'h6; // [R4] [R5]
      sscr_pkg::SSCR_LIM_C6R: pkg_limit_state = 3'h6; // [R4]
      sscr_pkg::SSCR_LIM_C7: pkg_limit_state = 3'h7; // [R4]
      sscr_pkg::SSCR_LIM_C7S: pkg_limit_state = 3'h7; // [R4]
      sscr_pkg::SSCR_LIM_RSVD: pkg_limit_none = 1'b1;
      sscr_pkg::SSCR_LIM_NONE: pkg_limit_none = 1'b1; // [R4]
    endcase
  end

  assign cfg_locked = ctrl_ff[`SSCR_CTRL_LOCK_BIT];

  // Demotion and redirection
  sscr_demote #(.IO_W(IO_W)) sscr_demote_i (
    .dem3_en(ctrl_ff[`SSCR_CTRL_DEM3_BIT]),
    .dem1_en(ctrl_ff[`SSCR_CTRL_DEM1_BIT]),
    .io_red_en(ctrl_ff[`SSCR_CTRL_IORED_BIT]),
    .io_base(io_base),
    .req_state(req_state),
    .uncore_dem3(uncore_dem3),
    .uncore_dem1(uncore_dem1),
    .io_rd(io_rd),
    .io_addr(io_addr),
    .grant_state(grant_state),
    .io_hit(io_hit)
  );
  // Non-captured reads go out as ordinary I/O
  assign io_forward = io_rd && !io_hit; // [R10]
endmodule

// file: dv/sscr_assertions.sv
// Checker for the sleep-state register bank
`timescale 1ns/1ps
module sscr_chk (
  input logic clock,
  input logic arst_n,
  input logic [11:0] reg_addr,
  input logic reg_wr,
  input logic reg_rd,
  input logic [63:0] reg_rdata,
  input logic [15:0] io_base,
  input logic [2:0] req_state,
  input logic uncore_dem3,
  input logic uncore_dem1,
  input logic io_rd,
  input logic [15:0] io_addr,
  input logic [2:0] grant_state,
  input logic io_hit,
  input logic io_forward,
  input logic [2:0] pkg_limit_state,
  input logic pkg_limit_none,
  input logic cfg_locked
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 64'h0)
    else $error("read data outside slot");
  a_info_read: assert property (
    $past(reg_rd) && $past(reg_addr) == 12'h0CE
    |-> reg_rdata == 64'h0000_0800_2000_0000)
    else $error("bad capability");
  a_ctrl_read: assert property (
    $past(reg_rd) && $past(reg_addr) == 12'h0E2
    |-> (reg_rdata & ~64'h0600_8407) == 64'h0 && reg_rdata[15] == cfg_locked
    && pkg_limit_none == (reg_rdata[2:1] == 2'h3)) else $error("bad control");
  a_lock_hold: assert property (
    cfg_locked && reg_wr |=> cfg_locked && $stable(pkg_limit_state))
    else $error("lock broken");
  a_lock_sticky: assert property (cfg_locked |=> cfg_locked)
    else $error("lock cleared without reset");
  a_no_c3: assert property (pkg_limit_state != 3'h3)
    else $error("limit reached C3");
  a_io_hit: assert property (io_hit |-> io_rd && io_addr == io_base)
    else $error("stray hit");
  a_io_fwd: assert property (
    io_rd && io_addr != io_base |-> io_forward && !io_hit)
    else $error("unmatched read not forwarded");
  a_no_hint: assert property (!uncore_dem3 && !uncore_dem1
    |-> grant_state == req_state) else $error("demoted without hint");
endmodule
bind sscr_top sscr_chk sscr_chk_i (.*);

// file: dv/test_sscr_top.sv
// Self-checking bench for the sleep-state register bank
`timescale 1ns/1ps
module test_sscr_top;
  logic clock = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, io_rd = 0, h;
  logic uncore_dem3 = 0, uncore_dem1 = 0, io_hit, io_forward;
  logic pkg_limit_none, cfg_locked;
  logic [11:0] reg_addr = 0;
  logic [63:0] reg_wdata = 0, reg_rdata, m;
  logic [15:0] io_base = 0, io_addr = 0;
  logic [2:0] req_state = 1, grant_state, pkg_limit_state, g;
  logic [2:0] lt [8] = '{3'h1, 3'h2, 3'h6, 3'h6, 3'h7, 3'h7, 3'h0, 3'h0};
  logic [31:0] s = 32'h6B92, v;
  int fails = 0, tests_run = 0;
  always #25 clock = ~clock;
  sscr_top sscr_top_i (.*);
  // Xorshift source
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Compare and count
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus write, control model follows the lock
  task automatic wr(logic [11:0] a, logic [63:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (a == 12'h0E2) m = m[15] ? m | (d & 64'h0600_0000) : d & 64'h0600_8407;
    if (a == 12'h0E2 && m[15]) m = (m & 64'h8407) | (d & 64'h0600_0000);
    #1;
  endtask
  // Bus read with check of the data slot
  task automatic rd(logic [11:0] a, logic [63:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Verdict and end of run
  task automatic results;
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    fails++;
    results;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    m = 64'h7;
    rd(12'h0E2, m);
    wr(12'h0CE, {rnd(), rnd()});
    rd(12'h0CE, 64'h0000_0800_2000_0000);
    rd(12'h0E4, 64'h0);
    $display("register reads done");
    for (int c = 0; c < 8; c++) begin
      wr(12'h0E2, 64'(c));
      if (c < 6) chk(pkg_limit_state, lt[c]);
      chk(pkg_limit_none, c > 5);
    end
    $display("limit codes done");
    repeat (40) begin
      wr(12'h0E2, {rnd(), rnd()} & ~64'h8000);
      rd(12'h0E2, m);
      v = rnd();
      @(posedge clock);
      req_state <= v[1:0] == 0 ? 3'h1 : v[1:0] == 1 ? 3'h3 : {2'h3, v[0]};
      {uncore_dem3, uncore_dem1, io_rd} <= v[4:2];
      io_base <= v[31:16];
      io_addr <= v[5] ? v[31:16] : v[21:6];
      #1;
      g = req_state;
      if (m[26] && uncore_dem1 && g > 3'h2) g = 3'h1;
      else if (m[25] && uncore_dem3 && g > 3'h5) g = 3'h3;
      h = m[10] && io_rd && io_addr == io_base;
      chk(grant_state, g);
      chk(io_hit, h);
      chk(io_forward, io_rd && !h);
    end
    $display("demotion done");
    wr(12'h0E2, 64'h8000);
    wr(12'h0E2, 64'h0600_0405);
    rd(12'h0E2, m);
    chk(cfg_locked, 1'b1);
    @(posedge clock);
    arst_n <= 1'b0;
    #1 chk(cfg_locked, 1'b0);
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(12'h0E2, 64'h7);
    $display("lock done");
    results;
  end
endmodule
